// ===== dv/core_bus_model.sv
// Core side of the register bus.
// Assumes one rising-edge clock.
`timescale 1ns/1ns
`default_nettype none
module core_bus_model
	import irq_mask_pkg::*;
(
	input wire logic clock,
	output var sfr_req_s sfr_req
);
	initial sfr_req = '0;
	// One strobe cycle, then address and data are scrambled, not held
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
		sfr_req <= '{w, ~w, a, d};
		@(posedge clock);
		sfr_req <= '{1'b0, 1'b0, ~a, ~d};
	endtask
endmodule
`default_nettype wire

// ===== dv/tb_extended_interrupt_enable_mask.sv
// Bench for the interrupt enable mask.
// Assumes the core model drives the bus.
`timescale 1ns/1ns
`default_nettype none
module tb_extended_interrupt_enable_mask
	import irq_mask_pkg::*;
;
	logic clock = 0;
	logic rst_n = 0;
	sfr_req_s sfr_req;
	irq_src_s irq_pending = '0;
	irq_src_s irq_to_core;
	logic [7:0] sfr_rdata, v;
	logic sfr_hit;
	logic [7:0] m = 8'h00;
	logic rd_d = 0;
	logic [7:0] exp_q[$];
	int n_mismatch = 0;
	int n_tests = 0;
	always #5 clock = ~clock;
	core_bus_model core_bus_model_inst (.clock(clock), .sfr_req(sfr_req));
	extended_interrupt_enable_mask extended_interrupt_enable_mask_inst (.clock(clock),
		.rst_n(rst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
		.irq_pending(irq_pending), .irq_to_core(irq_to_core));
	task automatic chk_irq(input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("MISMATCH irq_to_core exp %h got %h", e, g);
		end
	endtask
	task automatic chk_rdata(input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("MISMATCH sfr_rdata exp %h got %h", e, g);
		end
	endtask
	task automatic chk_hit(input logic e, input logic g);
		n_tests++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("MISMATCH sfr_hit exp %b got %b", e, g);
		end
	endtask
	task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		if (!w) exp_q.push_back(a == EXT_IRQ_EN_ONE_ADDR ? m : SFR_RDATA_IDLE);
		core_bus_model_inst.access(w, a, d);
		if (w && a == EXT_IRQ_EN_ONE_ADDR) m = d;
	endtask
	task automatic give_verdict();
		$display("n_tests %0d n_mismatch %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge clock) irq_pending <= irq_src_s'(8'($urandom));
	always @(posedge clock) rd_d <= sfr_req.rd;
	always @(negedge clock)
	begin
		chk_irq(irq_pending & m, irq_to_core);
		chk_hit((sfr_req.rd | sfr_req.wr) && sfr_req.addr == EXT_IRQ_EN_ONE_ADDR, sfr_hit);
		if (rd_d) chk_rdata(exp_q.pop_front(), sfr_rdata);
	end
	initial
	begin
		v = 8'($urandom(34285));
		repeat (16) @(posedge clock);
		rst_n <= 1;
		op(0, 8'hE6, 8'h00);
		// Walking ones first so each gate is seen alone
		for (int i = 0; i < 24; i++)
		begin
			v = (i < 8) ? 8'h01 << i : 8'($urandom);
			op(1, 8'hE6, v);
			op(1, 8'($urandom % 230), ~v);
			op(0, 8'hE6, 8'h00);
			op(0, 8'hE7, 8'h00);
		end
		repeat (4) @(posedge clock);
		give_verdict();
	end
	initial
	begin
		#20000;
		n_mismatch++;
		give_verdict();
	end
endmodule
`default_nettype wire

// ===== verilog/extended_interrupt_enable_mask.sv
// Extended interrupt enable mask: one byte register gating eight sources.
// Assumes the sources and the core's bus run on the same clock as this block.
// Contract
// - Bit 7 passes comparator B rising-edge request when set, blocks it when clear.
// - Bit 6 gates comparator B falling-edge request; 1 enables, 0 masks.
// - Bit 5 gates comparator A rising-edge request; 1 enables, 0 masks.
// - Bit 4 gates comparator A falling-edge request; 1 enables, 0 masks.
// - Bit 3 gates programmable counter array request; 1 enables, 0 masks.
// - Bit 2 gates ADC window-compare request; 1 enables, 0 masks.
// - Bit 1 gates SMBus controller request; 1 enables, 0 masks.
// - Bit 0 gates SPI controller request; 1 enables, 0 masks.
`timescale 1ns/1ns
`default_nettype none
module extended_interrupt_enable_mask
	import irq_mask_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire sfr_req_s sfr_req,
	output logic [7:0] sfr_rdata,
	output logic sfr_hit,
	input wire irq_src_s irq_pending,
	output var irq_src_s irq_to_core
);

	////////////////////////////////////////////////////////////////////////////
	// Register state
	logic [7:0] extended_irq_enable_one_q;
	logic [7:0] extended_irq_enable_one_d;
	logic [7:0] sfr_rdata_q;
	logic [7:0] sfr_rdata_d;
	logic [7:0] irq_mask;

	// Bus decode
	logic addr_hit;
	logic mask_wr;
	logic mask_rd;

	////////////////////////////////////////////////////////////////////////////
	// No page input: the address decodes the same whatever page is selected
	assign addr_hit = (sfr_req.addr == EXT_IRQ_EN_ONE_ADDR);
	assign mask_wr = sfr_req.wr & addr_hit;
	assign mask_rd = sfr_req.rd & addr_hit;
	assign sfr_hit = mask_wr | mask_rd;

	////////////////////////////////////////////////////////////////////////////
	// Mask register
	always_comb
	begin
		extended_irq_enable_one_d = extended_irq_enable_one_q;
		if (mask_wr)
			extended_irq_enable_one_d = sfr_req.wdata;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			extended_irq_enable_one_q <= EXT_IRQ_EN_ONE_RESET;
		else
			extended_irq_enable_one_q <= extended_irq_enable_one_d;
	end

	assign irq_mask = extended_irq_enable_one_q;

	////////////////////////////////////////////////////////////////////////////
	// Read path
	// Read and write in one cycle: the read returns the mask before the write
	always_comb
	begin
		sfr_rdata_d = SFR_RDATA_IDLE;
		if (mask_rd)
			sfr_rdata_d = extended_irq_enable_one_q;
	end

	// Unmapped reads return zero so the core's read mux can OR all answers
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			sfr_rdata_q <= SFR_RDATA_IDLE;
		else
			sfr_rdata_q <= sfr_rdata_d;
	end

	assign sfr_rdata = sfr_rdata_q;

	////////////////////////////////////////////////////////////////////////////
	// Request gating
	// Pure gates, so a mask write never disturbs the source's own flag
	always_comb
	begin
		irq_to_core.cmp_b_rise = irq_pending.cmp_b_rise
			& irq_mask[CMP_B_RISE_BIT];
		irq_to_core.cmp_b_fall = irq_pending.cmp_b_fall
			& irq_mask[CMP_B_FALL_BIT];
		irq_to_core.cmp_a_rise = irq_pending.cmp_a_rise
			& irq_mask[CMP_A_RISE_BIT];
		irq_to_core.cmp_a_fall = irq_pending.cmp_a_fall
			& irq_mask[CMP_A_FALL_BIT];
		irq_to_core.counter_array = irq_pending.counter_array
			& irq_mask[COUNTER_ARRAY_BIT];
		irq_to_core.adc_window = irq_pending.adc_window
			& irq_mask[ADC_WINDOW_BIT];
		irq_to_core.smbus_ctrl = irq_pending.smbus_ctrl
			& irq_mask[SMBUS_CTRL_BIT];
		irq_to_core.spi_ctrl = irq_pending.spi_ctrl
			& irq_mask[SPI_CTRL_BIT];
	end
	// Pending flags live in the sources; nothing here can clear them

	////////////////////////////////////////////////////////////////////////////
	sequence s_write_mask;
		sfr_req.wr && addr_hit;
	endsequence

	a_write_then_read: assert property (@(posedge clock) disable iff (!rst_n)
		s_write_mask ##1 (sfr_req.rd && addr_hit && !sfr_req.wr)
		|=> sfr_rdata == $past(sfr_req.wdata, 2))
		else $error("mask read does not return last write");
	a_cmp_b_rise: assert property (@(posedge clock) disable iff (!rst_n)
		irq_to_core.cmp_b_rise == (irq_pending.cmp_b_rise
		&& extended_irq_enable_one_q[CMP_B_RISE_BIT]))
		else $error("comparator B rise gate wrong");
	a_cmp_b_fall: assert property (@(posedge clock) disable iff (!rst_n)
		irq_to_core.cmp_b_fall == (irq_pending.cmp_b_fall
		&& extended_irq_enable_one_q[CMP_B_FALL_BIT]))
		else $error("comparator B fall gate wrong");
	a_cmp_a_rise: assert property (@(posedge clock) disable iff (!rst_n)
		irq_to_core.cmp_a_rise == (irq_pending.cmp_a_rise
		&& extended_irq_enable_one_q[CMP_A_RISE_BIT]))
		else $error("comparator A rise gate wrong");
	a_cmp_a_fall: assert property (@(posedge clock) disable iff (!rst_n)
		irq_to_core.cmp_a_fall == (irq_pending.cmp_a_fall
		&& extended_irq_enable_one_q[CMP_A_FALL_BIT]))
		else $error("comparator A fall gate wrong");
	a_counter_gate: assert property (@(posedge clock) disable iff (!rst_n)
		irq_to_core.counter_array == (irq_pending.counter_array
		&& extended_irq_enable_one_q[COUNTER_ARRAY_BIT]))
		else $error("counter array gate wrong");
	a_adc_gate: assert property (@(posedge clock) disable iff (!rst_n)
		irq_to_core.adc_window == (irq_pending.adc_window
		&& extended_irq_enable_one_q[ADC_WINDOW_BIT]))
		else $error("adc window gate wrong");
	a_smbus_gate: assert property (@(posedge clock) disable iff (!rst_n)
		irq_to_core.smbus_ctrl == (irq_pending.smbus_ctrl
		&& extended_irq_enable_one_q[SMBUS_CTRL_BIT]))
		else $error("smbus gate wrong");
	a_spi_gate: assert property (@(posedge clock) disable iff (!rst_n)
		irq_to_core.spi_ctrl == (irq_pending.spi_ctrl
		&& extended_irq_enable_one_q[SPI_CTRL_BIT]))
		else $error("spi gate wrong");
	a_write_takes_effect: assert property (@(posedge clock) disable iff (!rst_n)
		s_write_mask |=> irq_to_core == irq_src_s'(irq_pending & $past(sfr_req.wdata)))
		else $error("mask write not applied next cycle");

	////////////////////////////////////////////////////////////////////////////
	// Register access checks
	sequence s_read_mask;
		sfr_req.rd && addr_hit;
	endsequence

	sequence s_no_read;
		!(sfr_req.rd && addr_hit);
	endsequence

	sequence s_no_write;
		!(sfr_req.wr && addr_hit);
	endsequence

	a_read_returns_mask: assert property (@(posedge clock) disable iff (!rst_n)
		s_read_mask |=> sfr_rdata == $past(extended_irq_enable_one_q))
		else $error("mask read returns wrong value");

	a_idle_rdata_zero: assert property (@(posedge clock) disable iff (!rst_n)
		s_no_read |=> sfr_rdata == SFR_RDATA_IDLE)
		else $error("read data not zero outside a mask read");

	a_mask_holds: assert property (@(posedge clock) disable iff (!rst_n)
		s_no_write |=> $stable(extended_irq_enable_one_q))
		else $error("mask changed without a write");

	a_write_lands: assert property (@(posedge clock) disable iff (!rst_n)
		s_write_mask |=> extended_irq_enable_one_q == $past(sfr_req.wdata))
		else $error("mask write data not stored");

	a_hit_decode: assert property (@(posedge clock) disable iff (!rst_n)
		sfr_hit == ((sfr_req.rd || sfr_req.wr)
		&& sfr_req.addr == EXT_IRQ_EN_ONE_ADDR))
		else $error("register hit decode wrong");

	////////////////////////////////////////////////////////////////////////////
	// Whole-byte gating checks
	a_all_masked: assert property (@(posedge clock) disable iff (!rst_n)
		extended_irq_enable_one_q == 8'h00 |-> irq_to_core == irq_src_s'(8'h00))
		else $error("request passed with every bit masked");

	a_all_open: assert property (@(posedge clock) disable iff (!rst_n)
		extended_irq_enable_one_q == 8'hFF |-> irq_to_core == irq_pending)
		else $error("request blocked with every bit enabled");

	a_none_pending: assert property (@(posedge clock) disable iff (!rst_n)
		irq_pending == irq_src_s'(8'h00) |-> irq_to_core == irq_src_s'(8'h00))
		else $error("request raised with nothing pending");

endmodule
`default_nettype wire

// ===== verilog/irq_mask_pkg.sv
// Package for the extended interrupt enable mask register.
// Assumes a byte-wide special function register bus from the core.
package irq_mask_pkg;
	localparam logic [7:0] EXT_IRQ_EN_ONE_ADDR = 8'hE6;
	localparam logic [7:0] EXT_IRQ_EN_ONE_RESET = 8'h00;
	localparam logic [7:0] SFR_RDATA_IDLE = 8'h00;
	localparam int CMP_B_RISE_BIT = 7;
	localparam int CMP_B_FALL_BIT = 6;
	localparam int CMP_A_RISE_BIT = 5;
	localparam int CMP_A_FALL_BIT = 4;
	localparam int COUNTER_ARRAY_BIT = 3;
	localparam int ADC_WINDOW_BIT = 2;
	localparam int SMBUS_CTRL_BIT = 1;
	localparam int SPI_CTRL_BIT = 0;

	// One request line per source, in mask bit order
	typedef struct packed {
		logic cmp_b_rise;
		logic cmp_b_fall;
		logic cmp_a_rise;
		logic cmp_a_fall;
		logic counter_array;
		logic adc_window;
		logic smbus_ctrl;
		logic spi_ctrl;
	} irq_src_s;

	// Register access from the core
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_s;
endpackage
